// file: hdl/autobaud_detect.sv
// Auto-baud rate detection with baud generator, control registers and interrupt.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module autobaud_detect
    import autobaud_pkg::*;
(
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_RST_N,
    input  wire logic [3:0] I_ADDR,
    input  wire logic [7:0] I_WR_DATA,
    input  wire logic       I_WR_STB,
    input  wire logic       I_RD_STB,
    input  wire logic       I_RECEIVE_LINE,
    output logic      [7:0] O_RD_DATA,
    output logic            O_IRQ,
    output logic            O_BAUD_TICK,
    output logic            O_SERIAL_HOLD_IDLE
);

    // -------------------------------------------------------------------------
    // State and registers
    // -------------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE       = 5'b00001,
        ST_WAIT_BREAK = 5'b00010,
        ST_WAIT_START = 5'b00100,
        ST_WAIT_RISE  = 5'b01000,
        ST_COUNTING   = 5'b10000
    } detect_state_e;

    detect_state_e state;
    logic [15:0]   baud_count;
    logic [15:0]   baud_divide;
    logic [2:0]    rise_index;
    logic          autobaud_enable;
    logic          wake_up_enable;
    logic          high_speed_baud_select;
    logic          wide_baud_select;
    logic          sync_mode;
    logic          autobaud_overflow;
    logic          receive_flag;
    logic [1:0]    irq_status;
    logic [1:0]    irq_enable;

    logic rx_rise;
    logic rx_fall;
    logic tick;
    logic ctrl_wr;
    logic arm;
    logic detecting;
    logic count_step;
    logic wrap;
    logic fifth_rise;
    logic rx_hold_read;

    assign ctrl_wr      = I_WR_STB && I_ADDR == ADDR_BAUD_CONTROL;
    // Sync mode never arms: a stray arm there would clear the count and hold the engine.
    assign arm          = ctrl_wr && I_WR_DATA[BIT_AUTOBAUD_ENABLE] && !I_WR_DATA[BIT_SYNC_MODE]
                          && !autobaud_enable;
    assign detecting    = state != ST_IDLE;
    assign count_step   = state == ST_COUNTING && tick && !rx_rise;
    assign wrap         = count_step && baud_count == BAUD_COUNT_MAX;
    assign fifth_rise   = state == ST_COUNTING && rx_rise && rise_index == RISE_LAST_INDEX;
    assign rx_hold_read = I_RD_STB && I_ADDR == ADDR_RECEIVE_HOLDING;

    // -------------------------------------------------------------------------
    // Receive line and counter clock
    // -------------------------------------------------------------------------
    // Only the edge pulses matter here; the settled level is left unconnected.
    rx_line_sync i_rx_line_sync (
        .i_clk   (I_SYS_CLK),
        .i_rst_n (I_RST_N),
        .i_line  (I_RECEIVE_LINE),
        .o_level (),
        .o_rise  (rx_rise),
        .o_fall  (rx_fall)
    );

    // counter clock rate.
    // Restarting on the first rising edge keeps the measurement phase-aligned to the line.
    tick_divider i_tick_divider (
        .i_clk     (I_SYS_CLK),
        .i_rst_n   (I_RST_N),
        .i_restart (arm || (state == ST_WAIT_RISE && rx_rise)),
        .i_period  (tick_period(wide_baud_select, high_speed_baud_select, detecting)),
        .o_tick    (tick)
    );

    // -------------------------------------------------------------------------
    // Detection sequence
    // -------------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state      <= ST_IDLE;
            rise_index <= 3'h0;
        end else if (sync_mode || (ctrl_wr && !I_WR_DATA[BIT_AUTOBAUD_ENABLE])) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (arm && !I_WR_DATA[BIT_SYNC_MODE]) begin
                        state <= I_WR_DATA[BIT_WAKE_UP_ENABLE] ? ST_WAIT_BREAK : ST_WAIT_START;
                    end
                end
                ST_WAIT_BREAK: begin
                    if (rx_rise) begin
                        state <= ST_WAIT_START;
                    end
                end
                ST_WAIT_START: begin
                    if (rx_fall) begin
                        state <= ST_WAIT_RISE;
                    end
                end
                ST_WAIT_RISE: begin
                    if (rx_rise) begin
                        state      <= ST_COUNTING;
                        rise_index <= 3'h1;
                    end
                end
                ST_COUNTING: begin
                    // edges count over low and high bits.
                    if (fifth_rise) begin
                        state <= ST_IDLE;
                    end else if (rx_rise) begin
                        rise_index <= rise_index + 3'h1;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Baud count registers
    // -------------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            baud_count <= BAUD_RESET;
        end else if (arm) begin
            baud_count <= BAUD_RESET;
        end else if (count_step) begin
            baud_count <= baud_count + 16'h0001;
        end else if (!detecting && I_WR_STB && I_ADDR == ADDR_BAUD_COUNT_LOW) begin
            baud_count[7:0] <= I_WR_DATA;
        end else if (!detecting && I_WR_STB && I_ADDR == ADDR_BAUD_COUNT_HIGH) begin
            baud_count[15:8] <= I_WR_DATA;
        end
    end

    // normal baud generator.
    // The serial engine is fed only while no measurement is in flight.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            baud_divide <= BAUD_RESET;
            O_BAUD_TICK <= 1'b0;
        end else if (detecting || arm) begin
            // Arm is included so no normal tick slips out as the hold output rises.
            baud_divide <= BAUD_RESET;
            O_BAUD_TICK <= 1'b0;
        end else if (tick && baud_divide >= baud_count) begin
            baud_divide <= BAUD_RESET;
            O_BAUD_TICK <= 1'b1;
        end else begin
            baud_divide <= tick ? baud_divide + 16'h0001 : baud_divide;
            O_BAUD_TICK <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Control register
    // -------------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            autobaud_enable        <= CONTROL_RESET[BIT_AUTOBAUD_ENABLE];
            wake_up_enable         <= CONTROL_RESET[BIT_WAKE_UP_ENABLE];
            high_speed_baud_select <= CONTROL_RESET[BIT_HIGH_SPEED_SELECT];
            wide_baud_select       <= CONTROL_RESET[BIT_WIDE_SELECT];
            sync_mode              <= CONTROL_RESET[BIT_SYNC_MODE];
        end else if (ctrl_wr) begin
            autobaud_enable        <= I_WR_DATA[BIT_AUTOBAUD_ENABLE];
            wake_up_enable         <= I_WR_DATA[BIT_WAKE_UP_ENABLE];
            high_speed_baud_select <= I_WR_DATA[BIT_HIGH_SPEED_SELECT];
            wide_baud_select       <= I_WR_DATA[BIT_WIDE_SELECT];
            sync_mode              <= I_WR_DATA[BIT_SYNC_MODE];
        end else begin
            if (fifth_rise) begin
                autobaud_enable <= 1'b0;
            end
            if (state == ST_WAIT_BREAK && rx_rise) begin
                wake_up_enable <= 1'b0;
            end
        end
    end

    // overflow, hardware set wins over software write.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            autobaud_overflow <= CONTROL_RESET[BIT_AUTOBAUD_OVERFLOW];
        end else if (wrap) begin
            autobaud_overflow <= 1'b1;
        end else if (ctrl_wr) begin
            autobaud_overflow <= I_WR_DATA[BIT_AUTOBAUD_OVERFLOW];
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            receive_flag <= 1'b0;
        end else if (fifth_rise) begin
            receive_flag <= 1'b1;
        end else if (rx_hold_read) begin
            receive_flag <= 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SERIAL_HOLD_IDLE <= 1'b0;
        end else begin
            O_SERIAL_HOLD_IDLE <= detecting || arm;
        end
    end

    // -------------------------------------------------------------------------
    // Interrupt
    // -------------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            irq_status <= 2'h0;
            irq_enable <= 2'h0;
            O_IRQ      <= 1'b0;
        end else begin
            irq_status[IRQ_BIT_DONE] <= fifth_rise || (irq_status[IRQ_BIT_DONE]
                && !(I_WR_STB && I_ADDR == ADDR_IRQ_CLEAR && I_WR_DATA[IRQ_BIT_DONE]));
            irq_status[IRQ_BIT_OVERFLOW] <= wrap || (irq_status[IRQ_BIT_OVERFLOW]
                && !(I_WR_STB && I_ADDR == ADDR_IRQ_CLEAR && I_WR_DATA[IRQ_BIT_OVERFLOW]));
            if (I_WR_STB && I_ADDR == ADDR_IRQ_ENABLE) begin
                irq_enable <= I_WR_DATA[1:0];
            end
            O_IRQ <= |(irq_status & irq_enable);
        end
    end

    // -------------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------------
    // Receive holding reads as zero here; its only effect is clearing the flag.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RD_DATA <= 8'h00;
        end else if (!I_RD_STB) begin
            O_RD_DATA <= 8'h00;
        end else begin
            unique case (I_ADDR)
                ADDR_BAUD_CONTROL: begin
                    O_RD_DATA <= {autobaud_overflow, 1'b0, receive_flag, sync_mode, wide_baud_select,
                                  high_speed_baud_select, wake_up_enable, autobaud_enable};
                end
                ADDR_BAUD_COUNT_LOW: O_RD_DATA  <= baud_count[7:0];
                ADDR_BAUD_COUNT_HIGH: O_RD_DATA <= baud_count[15:8];
                ADDR_IRQ_STATUS: O_RD_DATA      <= {6'h00, irq_status};
                ADDR_IRQ_ENABLE: O_RD_DATA      <= {6'h00, irq_enable};
                default: O_RD_DATA              <= 8'h00;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence s_last_edge;
        fifth_rise && !ctrl_wr;
    endsequence

    sequence s_done_state;
        !autobaud_enable && receive_flag && state == ST_IDLE;
    endsequence

    sequence s_first_rise;
        state == ST_WAIT_RISE && rx_rise && !ctrl_wr && !sync_mode;
    endsequence

    AST_SYNC_ABORTS: assert property (sync_mode && detecting |=> state == ST_IDLE)
        else $error("Detection continued in synchronous mode.");
    AST_START_BEGINS: assert property (state == ST_WAIT_START && rx_fall && !ctrl_wr && !sync_mode
        |=> state == ST_WAIT_RISE)
        else $error("Start bit did not begin measurement.");
    AST_GATED_COUNT: assert property (count_step && !ctrl_wr |=> baud_count == $past(baud_count) + 16'h0001)
        else $error("Counter did not advance on a gated tick.");
    AST_ARM_CLEARS: assert property (arm |=> baud_count == 16'h0000 && O_SERIAL_HOLD_IDLE)
        else $error("Arming did not clear the count.");
    AST_FIRST_RISE: assert property (s_first_rise |=> state == ST_COUNTING && rise_index == 3'h1)
        else $error("First rising edge did not start counting.");
    AST_EDGE_STEP: assert property (state == ST_COUNTING && rx_rise && !fifth_rise && !ctrl_wr
        && !sync_mode |=> rise_index == $past(rise_index) + 3'h1 && state == ST_COUNTING)
        else $error("Rising edge inside the character was not counted.");
    AST_FIFTH_EDGE: assert property (s_last_edge |=> s_done_state)
        else $error("Fifth rising edge did not finish detection.");
    AST_OVERFLOW: assert property (wrap && !ctrl_wr
        |=> autobaud_overflow && autobaud_enable && baud_count == 16'h0000 && state == ST_COUNTING)
        else $error("Overflow not trapped or detection stopped.");
    // Spacing is judged only while detection lasts; the normal tick is eight times faster.
    AST_TICK_SPACING: assert property (detecting && tick |=> !(tick && detecting) [*8])
        else $error("Detection counter clock too fast.");
    AST_HOLD_IDLE: assert property (detecting |-> O_SERIAL_HOLD_IDLE && !O_BAUD_TICK)
        else $error("Serial engine not held idle.");
    AST_FLAG_CLEARS: assert property (rx_hold_read && !fifth_rise |=> !receive_flag)
        else $error("Receive holding read did not clear the flag.");
    AST_BREAK_FIRST: assert property (state == ST_WAIT_BREAK && rx_rise && !ctrl_wr && !sync_mode
        |=> state == ST_WAIT_START && !wake_up_enable)
        else $error("Break end did not lead to detection.");

endmodule

// file: hdl/autobaud_pkg.sv
// Shared constants for the auto-baud detection block.
package autobaud_pkg;

    // -------------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------------
    localparam logic [3:0] ADDR_BAUD_CONTROL    = 4'h0;
    localparam logic [3:0] ADDR_BAUD_COUNT_LOW  = 4'h1;
    localparam logic [3:0] ADDR_BAUD_COUNT_HIGH = 4'h2;
    localparam logic [3:0] ADDR_RECEIVE_HOLDING = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS      = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLEAR       = 4'h5;
    localparam logic [3:0] ADDR_IRQ_ENABLE      = 4'h6;

    // -------------------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------------------
    localparam int BIT_AUTOBAUD_ENABLE   = 0;
    localparam int BIT_WAKE_UP_ENABLE    = 1;
    localparam int BIT_HIGH_SPEED_SELECT = 2;
    localparam int BIT_WIDE_SELECT       = 3;
    localparam int BIT_SYNC_MODE         = 4;
    localparam int BIT_RECEIVE_FLAG      = 5;
    localparam int BIT_AUTOBAUD_OVERFLOW = 7;

    // Interrupt status fields.
    localparam int IRQ_BIT_DONE     = 0;
    localparam int IRQ_BIT_OVERFLOW = 1;

    // -------------------------------------------------------------------------
    // Reset values and counts
    // -------------------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RESET   = 8'h00;
    localparam logic [15:0] BAUD_RESET      = 16'h0000;
    localparam logic [15:0] BAUD_COUNT_MAX  = 16'hFFFF;
    localparam logic [2:0]  RISE_LAST_INDEX = 3'h4;
    localparam logic [9:0]  DETECT_DIV_00   = 10'h200;
    localparam logic [9:0]  DETECT_DIV_01   = 10'h080;
    localparam logic [9:0]  DETECT_DIV_10   = 10'h080;
    localparam logic [9:0]  DETECT_DIV_11   = 10'h020;
    localparam int          DETECT_SLOWDOWN = 8;

    // Counter clock period in system clocks, detection or normal running.
    function automatic logic [9:0] tick_period(input logic wide, input logic fast, input logic detect);
        logic [9:0] div;
        div = DETECT_DIV_00;
        unique case ({wide, fast})
            2'b00: div = DETECT_DIV_00;
            2'b01: div = DETECT_DIV_01;
            2'b10: div = DETECT_DIV_10;
            2'b11: div = DETECT_DIV_11;
        endcase
        return detect ? div : 10'(div / DETECT_SLOWDOWN);
    endfunction

endpackage

// file: hdl/rx_line_sync.sv
// Two-stage synchroniser for the receive line with edge pulses.
`timescale 1ns/1ps
module rx_line_sync
    import autobaud_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_line,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);

    logic meta;
    logic stable;
    logic last;

    // The line idles high, so reset to high to avoid a false start bit.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta   <= 1'b1;
            stable <= 1'b1;
            last   <= 1'b1;
        end else begin
            meta   <= i_line;
            stable <= meta;
            last   <= stable;
        end
    end

    assign o_level = stable;
    assign o_rise  = stable & ~last;
    assign o_fall  = ~stable & last;

endmodule

// file: hdl/tick_divider.sv
// Free-running divider that pulses once per programmed period.
`timescale 1ns/1ps
module tick_divider
    import autobaud_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_restart,
    input  wire logic [9:0] i_period,
    output logic            o_tick
);

    logic [9:0] count;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count  <= 10'h000;
            o_tick <= 1'b0;
        end else if (i_restart || count + 10'h001 >= i_period) begin
            count  <= 10'h000;
            o_tick <= ~i_restart;
        end else begin
            count  <= count + 10'h001;
            o_tick <= 1'b0;
        end
    end

endmodule

// file: testbench/sync_char_sender.sv
// Remote serial transmitter model sending calibration and break frames.
`timescale 1ns/1ps
module sync_char_sender (
    input  wire logic i_clk,
    output logic      o_line
);
    initial o_line = 1'b1;

    task automatic send_byte(input int bit_cycles, input logic [7:0] data);
        logic [9:0] frame;
        frame = {1'b1, data, 1'b0};
        for (int b = 0; b < 10; b++) begin
            @(posedge i_clk) o_line <= frame[b];
            repeat (bit_cycles - 1) @(posedge i_clk);
        end
    endtask

    // Thirteen low bit times, then the line returns to its idle high level.
    task automatic send_break(input int bit_cycles);
        @(posedge i_clk) o_line <= 1'b0;
        repeat (13 * bit_cycles - 1) @(posedge i_clk);
        @(posedge i_clk) o_line <= 1'b1;
        repeat (bit_cycles) @(posedge i_clk);
    endtask
endmodule

// file: testbench/autobaud_detect_tb.sv
// Self-checking bench for the auto-baud detection block.
`timescale 1ns/1ps
module autobaud_detect_tb;
    import autobaud_pkg::*;
    logic       sys_clk  = 1'b0;
    logic       rst_n    = 1'b0;
    logic [3:0] addr     = 4'h0;
    logic [7:0] wr_data  = 8'h00;
    logic       wr_stb   = 1'b0;
    logic       rd_stb   = 1'b0;
    logic       rx_line;
    logic [7:0] rd_data;
    logic       irq;
    logic       baud_tick;
    logic       hold_idle;
    int         errors   = 0;
    int         n_checks = 0;
    int         cycles   = 0;
    int         p_table [4] = '{512, 128, 128, 32};

    always #2 sys_clk = ~sys_clk;

    autobaud_detect i_autobaud_detect (
        .I_SYS_CLK         (sys_clk),
        .I_RST_N           (rst_n),
        .I_ADDR            (addr),
        .I_WR_DATA         (wr_data),
        .I_WR_STB          (wr_stb),
        .I_RD_STB          (rd_stb),
        .I_RECEIVE_LINE    (rx_line),
        .O_RD_DATA         (rd_data),
        .O_IRQ             (irq),
        .O_BAUD_TICK       (baud_tick),
        .O_SERIAL_HOLD_IDLE(hold_idle)
    );

    sync_char_sender i_sync_char_sender (.i_clk(sys_clk), .o_line(rx_line));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The ceiling is well above the longest run of the scenarios below.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (hold_idle === 1'b1) chk("tick_in_detect", 16'h0, {15'h0, baud_tick});
        if (cycles == 90000) begin
            errors = errors + 1;
            print_verdict();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic wait_tick(input int lim, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (baud_tick !== 1'b1 && n < lim);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        logic [7:0] v;
        rd(ADDR_BAUD_CONTROL, v);
        chk("control_reset", {8'h0, CONTROL_RESET}, {8'h0, v});
        rd(ADDR_BAUD_COUNT_HIGH, v);
        chk("high_reset", BAUD_RESET, {8'h0, v});
        wr(ADDR_BAUD_COUNT_LOW, 8'hA5);
        rd(ADDR_BAUD_COUNT_LOW, v);
        chk("low_written", 16'h00A5, {8'h0, v});
        rd(4'hF, v);
        chk("unmapped", 16'h0000, {8'h0, v});
        wr(ADDR_BAUD_CONTROL, 8'h80);
        rd(ADDR_BAUD_CONTROL, v);
        chk("overflow_set_sw", 16'h0080, {8'h0, v});
        wr(ADDR_BAUD_CONTROL, 8'h00);
        rd(ADDR_BAUD_CONTROL, v);
        chk("overflow_clr_sw", 16'h0000, {8'h0, v});
    endtask

    task automatic detect_once(input int m, input logic wake);
        int p;
        int n;
        logic [7:0] v;
        logic [7:0] lo;
        p = p_table[m];
        wr(ADDR_BAUD_COUNT_LOW, 8'h5A);
        wr(ADDR_BAUD_CONTROL, {4'h0, m[1], m[0], wake, 1'b1});
        @(posedge sys_clk);
        #1 chk("hold_armed", 16'h1, {15'h0, hold_idle});
        rd(ADDR_BAUD_COUNT_LOW, v);
        chk("count_cleared", 16'h0, {8'h0, v});
        if (wake) i_sync_char_sender.send_break(p * 4);
        i_sync_char_sender.send_byte(p * 4, 8'h55);
        for (n = 0; n < 8 && hold_idle === 1'b1; n++) @(posedge sys_clk);
        chk("detect_done", 16'h0, {15'h0, hold_idle});
        rd(ADDR_BAUD_COUNT_LOW, lo);
        n_checks++;
        // Eight bit times of four counter periods; a tick on the final edge may be dropped.
        if (lo !== 8'h20 && lo !== 8'h1F) begin
            errors++;
            $display("wrong value count_low expected 1f seen %h", lo);
        end
        rd(ADDR_BAUD_COUNT_HIGH, v);
        chk("count_high", 16'h0, {8'h0, v});
        rd(ADDR_BAUD_CONTROL, v);
        chk("control_done", {8'h0, 4'h2, m[1], m[0], 2'b00}, {8'h0, v});
        rd(ADDR_IRQ_STATUS, v);
        chk("status_done", 16'h1, {8'h0, v});
        chk("irq_raised", 16'h1, {15'h0, irq});
        wr(ADDR_IRQ_ENABLE, 8'h00);
        @(posedge sys_clk);
        #1 chk("irq_masked", 16'h0, {15'h0, irq});
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        @(posedge sys_clk);
        #1 chk("irq_cleared", 16'h0, {15'h0, irq});
        rd(ADDR_RECEIVE_HOLDING, v);
        rd(ADDR_BAUD_CONTROL, v);
        chk("flag_cleared", 16'h0, {15'h0, v[5]});
        wait_tick(p * 80, n);
        wait_tick(p * 80, n);
        chk("tick_gap", 16'((p / 8) * (lo + 1)), n[15:0]);
    endtask

    task automatic test_sync_block();
        logic [7:0] v;
        wr(ADDR_BAUD_CONTROL, 8'h11);
        #1 chk("sync_no_arm", 16'h0, {15'h0, hold_idle});
        wr(ADDR_BAUD_CONTROL, 8'h00);
        wr(ADDR_BAUD_CONTROL, 8'h01);
        wr(ADDR_BAUD_CONTROL, 8'h11);
        repeat (2) @(posedge sys_clk);
        #1 chk("sync_abort", 16'h0, {15'h0, hold_idle});
        i_sync_char_sender.send_byte(128, 8'h55);
        rd(ADDR_BAUD_CONTROL, v);
        chk("sync_no_flag", 16'h0, {15'h0, v[5]});
        wr(ADDR_BAUD_CONTROL, 8'h00);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        test_reset();
        wr(ADDR_IRQ_ENABLE, 8'h01);
        for (int m = 0; m < 4; m++) detect_once(m, 1'b0);
        detect_once(3, 1'b1);
        test_sync_block();
        print_verdict();
    end
endmodule
